/* src/preset_speed_defines.svh */
// Function
// (R1) Ramp mode picks shared or per-speed times
// (R2) Eight preset speeds, 0 to 650.00 Hz
// (R3) Each preset owns accel and decel time
// (R4) Shared mode uses global pair one or two
// (R5) Individual mode uses the preset's own times
// (R6) Ramp time scales by frequency over maximum
// (R7) Pattern seven uses programmed maximum frequency
// (R8) Fixed patterns use 50 or 60 Hz
// (R9) Pulsed run ramps from and to zero
// (R10) Continuous run ramps by speed difference
// (R11) Three inputs weight 1, 2, 4 select preset
// (R12) Sequencer modes: off, single, periodic, hold
// (R13) Modes 1-3 resume, 4-6 restart step 0
// (R14) Step zero frequency is preset speed zero
// (R15) Steps 1-7 have own frequency setting
// (R16) Every step has a run time
// (R17) Step direction: stop, forward, reverse
// (R18) Enable input turns the sequencer on
// (R19) Single cycle runs steps once, then stops
// (R20) Sequencer ramps use global time pair
// (R21) Zero time and frequency marks unused step
// (R22) Step timer counts 0.1 second ticks
`ifndef PRESET_SPEED_DEFINES_SVH
`define PRESET_SPEED_DEFINES_SVH
`define CLK_HZ 25000000
`define TICK_MS 100
`define FREQ_MAX_SET 16'hfde8
`define TIME_MAX_SET 16'h8ca0
`define FMAX_50HZ 16'h1388
`define FMAX_60HZ 16'h1770
`define VF_PROG 4'h7
`define VF_LAST_50HZ 4'h2
`define SEQ_NEW_CYCLE 3'h4
`define SEQ_LAST_MODE 3'h6
`define DIR_STOP 2'h0
`define DIR_REV 2'h2
`define GRP_MISC 3'h0
`define GRP_PFREQ 3'h1
`define GRP_PACC 3'h2
`define GRP_PDEC 3'h3
`define GRP_SFREQ 3'h4
`define GRP_STIME 3'h5
`define GRP_SDIR 3'h6
`define REG_CTRL 3'h0
`define REG_FMAX 3'h1
`define REG_STATUS 3'h6
`define PIN_RUN 0
`define PIN_REV 1
`define PIN_SEL 2
`define PIN_SEQ 5
`endif

/* src/preset_speed_pkg.sv */
package preset_speed_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_HOLD = 2'b10,
    SEQ_DONE = 2'b11
  } seq_t;
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic ack;
    logic [31:0] rdat;
    logic ramp_mode;
    logic acc_sel;
    logic [2:0] seq_mode;
    logic [3:0] vf_pat;
    logic [15:0] fmax_set;
    logic [3:0][15:0] gtime;
    logic [7:0][15:0] pfreq;
    logic [7:0][15:0] pacc;
    logic [7:0][15:0] pdec;
    logic [7:0][15:0] sfreq;
    logic [7:0][15:0] stime;
    logic [7:0][1:0] sdir;
    logic [15:0] fout;
    logic rev;
    logic [39:0] acc;
    logic [31:0] tick;
    seq_t seq;
    logic [2:0] step;
    logic [15:0] stmr;
  } state_t;
endpackage : preset_speed_pkg

/* src/preset_speed_auto_sequencer.sv */
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "preset_speed_defines.svh"
module preset_speed_auto_sequencer
  import preset_speed_pkg::*;
#(
  parameter int TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS
)(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Terminals
  input wire logic MULTI_INPUT_ONE,
  input wire logic DIR_REVERSE_IN,
  input wire logic SPEED_SELECT_BIT0,
  input wire logic SPEED_SELECT_BIT1,
  input wire logic SPEED_SELECT_BIT2,
  input wire logic SEQ_ENABLE_IN,
  // Frequency command
  output logic [15:0] FREQ_OUT,
  output logic DIR_REV_OUT,
  output logic [2:0] SEQ_STEP,
  output logic [1:0] SEQ_STATE
);
  state_t q;
  state_t s;
  logic hit;
  logic run;
  logic seq_go;
  logic [2:0] sel;
  logic [2:0] grp;
  logic [2:0] idx;
  logic [31:0] rd;
  logic [7:0] used;
  logic [2:0] nxt;
  logic found;
  logic step_end;
  logic [15:0] fmax;
  logic [15:0] tgt;
  logic rev_cmd;
  logic [15:0] acc_t;
  logic [15:0] dec_t;
  logic up;
  logic [15:0] t;
  logic [39:0] den;
  logic [39:0] accn;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] be, input logic [15:0] lim);
    logic [15:0] v;
    v = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    merge = (v > lim) ? lim : v;
  endfunction : merge

  function automatic logic [15:0] step_freq(input state_t st, input logic [2:0] i);
    step_freq = (i == 3'h0) ? st.pfreq[0] : st.sfreq[i]; // [R14] [R15]
  endfunction : step_freq

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s = q;
    s.s1 = {SEQ_ENABLE_IN, SPEED_SELECT_BIT2, SPEED_SELECT_BIT1, SPEED_SELECT_BIT0,
            DIR_REVERSE_IN, MULTI_INPUT_ONE};
    s.s2 = q.s1;
    run = q.s2[`PIN_RUN];
    sel = q.s2[`PIN_SEL+:3]; // [R11]
    // Bus decode
    hit = WB_CYC_I & WB_STB_I;
    grp = WB_ADR_I[7:5];
    idx = WB_ADR_I[4:2];
    rd = 32'h0;
    if (WB_ADR_I[31:8] == 24'h0)
    begin
      unique case (grp)
        `GRP_MISC:
        begin
          if (idx == `REG_CTRL)
            rd = {23'h0, q.vf_pat, q.seq_mode, q.acc_sel, q.ramp_mode};
          else if (idx == `REG_FMAX)
            rd = {16'h0, q.fmax_set};
          else if (idx == `REG_STATUS)
            rd = {10'h0, q.seq, q.step, q.rev, q.fout};
          else if (idx >= 3'h2 && idx <= 3'h5)
            rd = {16'h0, q.gtime[idx - 3'h2]};
        end
        `GRP_PFREQ: rd = {16'h0, q.pfreq[idx]};
        `GRP_PACC: rd = {16'h0, q.pacc[idx]};
        `GRP_PDEC: rd = {16'h0, q.pdec[idx]};
        `GRP_SFREQ: rd = {16'h0, (idx == 3'h0) ? 16'h0 : q.sfreq[idx]};
        `GRP_STIME: rd = {16'h0, q.stime[idx]};
        `GRP_SDIR: rd = {30'h0, q.sdir[idx]};
        default: rd = 32'h0;
      endcase
    end
    s.ack = hit & ~q.ack;
    if (hit & ~q.ack)
      s.rdat = rd;
    if (hit & q.ack & WB_WE_I & (WB_ADR_I[31:8] == 24'h0))
    begin
      unique case (grp)
        `GRP_MISC:
        begin
          if (idx == `REG_CTRL && WB_SEL_I[0])
          begin
            s.ramp_mode = WB_DAT_I[0]; // [R1]
            s.acc_sel = WB_DAT_I[1];
            s.seq_mode = WB_DAT_I[4:2];
          end
          if (idx == `REG_CTRL && WB_SEL_I[1])
            s.vf_pat = WB_DAT_I[8:5];
          if (idx == `REG_FMAX)
            s.fmax_set = merge(q.fmax_set, WB_DAT_I, WB_SEL_I, `FREQ_MAX_SET);
          if (idx >= 3'h2 && idx <= 3'h5)
            s.gtime[idx - 3'h2] = merge(q.gtime[idx - 3'h2], WB_DAT_I, WB_SEL_I,
                                        `TIME_MAX_SET);
        end
        `GRP_PFREQ: s.pfreq[idx] = merge(q.pfreq[idx], WB_DAT_I, WB_SEL_I, `FREQ_MAX_SET); // [R2]
        `GRP_PACC: s.pacc[idx] = merge(q.pacc[idx], WB_DAT_I, WB_SEL_I, `TIME_MAX_SET); // [R3]
        `GRP_PDEC: s.pdec[idx] = merge(q.pdec[idx], WB_DAT_I, WB_SEL_I, `TIME_MAX_SET); // [R3]
        `GRP_SFREQ:
          if (idx != 3'h0)
            s.sfreq[idx] = merge(q.sfreq[idx], WB_DAT_I, WB_SEL_I, `FREQ_MAX_SET); // [R15]
        `GRP_STIME: s.stime[idx] = merge(q.stime[idx], WB_DAT_I, WB_SEL_I, `TIME_MAX_SET); // [R16]
        `GRP_SDIR:
          if (WB_SEL_I[0] && WB_DAT_I[1:0] <= `DIR_REV)
            s.sdir[idx] = WB_DAT_I[1:0]; // [R17]
        default: s.sdir = q.sdir;
      endcase
    end
    // Step scan
    for (int i = 0; i < 8; i++)
      used[i] = (q.stime[i] != 16'h0) || (step_freq(q, 3'(i)) != 16'h0); // [R21]
    nxt = 3'h0;
    found = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      if (3'(i) > q.step && used[i])
      begin
        nxt = 3'(i);
        found = 1'b1;
      end
    end
    // Sequencer
    seq_go = run & q.s2[`PIN_SEQ] & (q.seq_mode != 3'h0) & (q.seq_mode <= `SEQ_LAST_MODE); // [R18] [R12]
    step_end = q.stmr >= q.stime[q.step]; // [R22]
    unique case (q.seq)
      SEQ_IDLE:
        if (seq_go)
        begin
          s.seq = SEQ_RUN;
          if (q.seq_mode >= `SEQ_NEW_CYCLE)
          begin
            s.step = 3'h0; // [R13]
            s.stmr = 16'h0;
            s.tick = 32'h0;
          end
        end
      SEQ_RUN:
        if (!seq_go)
          s.seq = SEQ_IDLE; // [R13]
        else if (step_end)
        begin
          s.stmr = 16'h0;
          s.tick = 32'h0;
          if (found)
            s.step = nxt; // [R21]
          else if (q.seq_mode == 3'h2 || q.seq_mode == 3'h5)
            s.step = 3'h0; // [R12]
          else if (q.seq_mode == 3'h3 || q.seq_mode == `SEQ_LAST_MODE)
            s.seq = SEQ_HOLD; // [R12]
          else
            s.seq = SEQ_DONE; // [R19]
        end
        else if (q.tick == 32'(TICK_CYCLES - 1))
        begin
          s.tick = 32'h0;
          s.stmr = 16'(q.stmr + 16'h1); // [R22]
        end
        else
          s.tick = 32'(q.tick + 32'h1);
      SEQ_HOLD, SEQ_DONE:
        if (!seq_go)
        begin
          s.seq = SEQ_IDLE;
          s.step = 3'h0;
          s.stmr = 16'h0;
        end
    endcase
    // Ramp targets
    if (q.vf_pat == `VF_PROG)
      fmax = (q.fmax_set == 16'h0) ? 16'h1 : q.fmax_set; // [R7]
    else
      fmax = (q.vf_pat <= `VF_LAST_50HZ) ? `FMAX_50HZ : `FMAX_60HZ; // [R8]
    if (q.seq != SEQ_IDLE)
    begin
      tgt = (q.seq == SEQ_DONE || q.sdir[q.step] == `DIR_STOP) ? 16'h0
            : step_freq(q, q.step); // [R17] [R19]
      rev_cmd = q.sdir[q.step] == `DIR_REV;
    end
    else
    begin
      tgt = run ? q.pfreq[sel] : 16'h0; // [R9]
      rev_cmd = q.s2[`PIN_REV];
    end
    if (q.seq != SEQ_IDLE || !q.ramp_mode)
    begin
      acc_t = q.gtime[{q.acc_sel, 1'b0}]; // [R4] [R20]
      dec_t = q.gtime[{q.acc_sel, 1'b1}];
    end
    else
    begin
      acc_t = q.pacc[sel]; // [R5]
      dec_t = q.pdec[sel];
    end
    if (rev_cmd != q.rev)
    begin
      tgt = 16'h0;
      if (q.fout == 16'h0)
        s.rev = rev_cmd;
    end
    // Ramp engine: slope of fmax per programmed time
    up = tgt > q.fout;
    t = up ? acc_t : dec_t;
    den = 40'(t) * 40'(TICK_CYCLES);
    accn = q.acc + {24'h0, fmax};
    if (tgt == q.fout)
      s.acc = 40'h0;
    else if (t == 16'h0)
    begin
      s.fout = tgt;
      s.acc = 40'h0;
    end
    else if (accn >= den)
    begin
      s.acc = accn - den; // [R6] [R10]
      s.fout = up ? 16'(q.fout + 16'h1) : 16'(q.fout - 16'h1);
    end
    else
      s.acc = accn;
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      q <= '0;
    else
      q <= s;
  end

  assign WB_ACK_O = q.ack;
  assign WB_DAT_O = q.rdat;
  assign FREQ_OUT = q.fout;
  assign DIR_REV_OUT = q.rev;
  assign SEQ_STEP = q.step;
  assign SEQ_STATE = q.seq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence seq_enter;
    q.seq == SEQ_IDLE && seq_go;
  endsequence

  sequence seq_done_step;
    q.seq == SEQ_RUN && seq_go && step_end && found;
  endsequence

  a_freq_limit: assert property (q.fout <= `FREQ_MAX_SET) // [R2]
    else $error("output frequency above limit");
  a_new_cycle: assert property (seq_enter and q.seq_mode >= `SEQ_NEW_CYCLE |=> // [R13]
    q.step == 3'h0 && q.stmr == 16'h0)
    else $error("restart did not begin at step zero");
  a_resume_step: assert property (seq_enter and q.seq_mode < `SEQ_NEW_CYCLE |=> // [R13]
    $stable(q.step) && q.seq == SEQ_RUN)
    else $error("restart lost the unfinished step");
  a_step_advance: assert property (seq_done_step |=> q.step == $past(nxt) // [R22]
    && q.stmr == 16'h0)
    else $error("step did not advance on time");
  a_used_step: assert property (q.seq == SEQ_RUN && $changed(q.step) && q.step != 3'h0 // [R21]
    |-> used[q.step])
    else $error("sequencer entered an unused step");
  a_single_stop: assert property (q.seq == SEQ_DONE ##1 q.seq == SEQ_DONE // [R19]
    |-> q.fout <= $past(q.fout))
    else $error("output rose after single cycle");
  a_rev_at_zero: assert property ($changed(q.rev) |-> $past(q.fout) == 16'h0) // [R17]
    else $error("direction flipped while running");
  a_mode_off: assert property (q.seq_mode == 3'h0 |=> q.seq == SEQ_IDLE) // [R12]
    else $error("sequencer active while disabled");
  a_ramp_dir: assert property (q.fout > $past(q.fout) |-> $past(up)) // [R6]
    else $error("ramp moved away from target");
  a_hold_step: assert property (q.seq == SEQ_HOLD ##1 q.seq == SEQ_HOLD |-> $stable(q.step)) // [R12]
    else $error("hold state changed step");
endmodule : preset_speed_auto_sequencer
`default_nettype wire

/* bench/term_model.sv */
`timescale 1ns/1ps
`default_nettype none
module term_model (
  // Bench commands
  input wire logic clk,
  input wire logic run,
  input wire logic [2:0] idx,
  input wire logic seq_en,
  // Terminal pins
  output logic run_pin,
  output logic [2:0] sel_pin,
  output logic seq_pin
);
  always_ff @(posedge clk)
  begin
    run_pin <= run;
    sel_pin <= idx;
    seq_pin <= seq_en;
  end
endmodule : term_model
`default_nettype wire

/* bench/preset_speed_auto_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module preset_speed_auto_sequencer_tb;
  // ----------------
  // Signals
  // ----------------
  logic CLK = 1'b0, RST = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic run = 1'b0, seq = 1'b0, rv = 1'b0, ack, run_p, seq_p, dro;
  logic [31:0] adr = 32'h0, wd = 32'h0, rd, dat_o;
  logic [3:0] sel = 4'h0;
  logic [2:0] idx = 3'h0, sp, st;
  logic [15:0] fo;
  logic [1:0] ss;
  int err_total = 0, tests_run = 0, seed = 79555, n, m, v;
  int fm[4] = '{5000, 5000, 6000, 10000};
  int tm[4] = '{1000, 2000, 2000, 2000};
  logic [31:0] ctl[4] = '{32'h0, 32'h1, 32'h61, 32'he1};
  logic [31:0] cfg[24] = '{32'h20, 32'h12c, 32'h24, 32'hc8, 32'h28, 32'h258,
    32'h08, 32'h3e8, 32'h44, 32'h7d0, 32'h48, 32'h7d0, 32'h04, 32'h2710,
    32'h84, 32'h2bc, 32'ha0, 32'h2, 32'ha4, 32'h3, 32'hc0, 32'h1, 32'hc4, 32'h2};

  always #20 CLK = ~CLK;

  preset_speed_auto_sequencer #(.TICK_CYCLES(10)) i_dut (.CLK(CLK), .RST(RST),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wd), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .MULTI_INPUT_ONE(run_p),
    .DIR_REVERSE_IN(rv), .SPEED_SELECT_BIT0(sp[0]), .SPEED_SELECT_BIT1(sp[1]),
    .SPEED_SELECT_BIT2(sp[2]), .SEQ_ENABLE_IN(seq_p), .FREQ_OUT(fo),
    .DIR_REV_OUT(dro), .SEQ_STEP(st), .SEQ_STATE(ss));

  term_model i_term (.clk(CLK), .run(run), .idx(idx), .seq_en(seq),
    .run_pin(run_p), .sel_pin(sp), .seq_pin(seq_p));

  // ----------------
  // Tasks
  // ----------------
  task conclude;
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= 4'hf;
    n = 0;
    do @(posedge CLK) n++; while (ack !== 1'b1 && n < 20);
    chk(32'(n < 20), 32'h1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task rchk(input logic [31:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk

  function automatic int rt(input int t, input int f, input int fmax);
    return t * 10 * f / fmax;
  endfunction : rt

  task ramp_to(input logic [15:0] tgt, input int ex);
    n = 0;
    while (fo !== tgt && n < 3000)
    begin
      @(posedge CLK);
      n++;
    end
    chk(32'(n >= ex * 9 / 10 && n <= ex * 11 / 10 + 8), 32'h1);
  endtask : ramp_to

  task till(input logic [4:0] s, input logic hit);
    n = 0;
    while (({ss, st} === s) !== hit && n < 400)
    begin
      @(posedge CLK);
      n++;
    end
    chk(32'(n < 400), 32'h1);
  endtask : till

  // ----------------
  // Stimulus
  // ----------------
  initial
  begin
    repeat (30000) @(posedge CLK);
    err_total++;
    conclude();
  end

  initial
  begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    rchk(32'h0, 32'h0);
    rchk(32'h18, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      v = {$random(seed)} % 65001;
      wb(1'b1, 32'h20 + 4 * i, v);
      rchk(32'h20 + 4 * i, v);
    end
    wb(1'b1, 32'h24, 32'hffff);
    rchk(32'h24, 32'hfde8);
    wb(1'b1, 32'h40, 32'hffff);
    rchk(32'h40, 32'h8ca0);
    wb(1'b1, 32'h80, 32'h5);
    rchk(32'h80, 32'h0);
    wb(1'b1, 32'hc0, 32'h3);
    rchk(32'hc0, 32'h0);
    wb(1'b1, 32'h104, 32'h5);
    rchk(32'h104, 32'h0);
    for (int i = 0; i < 24; i += 2)
      wb(1'b1, cfg[i], cfg[i + 1]);
    rchk(32'ha4, 32'h3);
    idx <= 3'h1;
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, 32'h0, ctl[i]);
      rv <= (i == 3);
      run <= 1'b1;
      ramp_to(16'hc8, rt(tm[i], 200, fm[i]));
      chk(dro, 32'(i == 3));
      idx <= 3'h2;
      ramp_to(16'h258, rt(tm[i], 400, fm[i]));
      run <= 1'b0;
      ramp_to(16'h0, 0);
      idx <= 3'h1;
      rv <= 1'b0;
    end
    for (m = 1; m < 7; m++)
    begin
      wb(1'b1, 32'h0, 32'h2 | (m << 2));
      seq <= 1'b1;
      run <= 1'b1;
      till({2'h1, 3'h1}, 1'b1);
      repeat (8) @(posedge CLK);
      chk(fo, 32'h2bc);
      chk(dro, 32'h1);
      run <= 1'b0;
      repeat (8) @(posedge CLK);
      run <= 1'b1;
      repeat (6) @(posedge CLK);
      chk(st, (m < 4) ? 32'h1 : 32'h0);
      till({2'h1, 3'h1}, 1'b1);
      till({2'h1, 3'h1}, 1'b0);
      repeat (8) @(posedge CLK);
      chk(ss, (m % 3 == 1) ? 32'h3 : (m % 3 == 0) ? 32'h2 : 32'h1);
      chk(fo, (m % 3 == 1) ? 32'h0 : (m % 3 == 0) ? 32'h2bc : 32'h12c);
      seq <= 1'b0;
      run <= 1'b0;
      repeat (10) @(posedge CLK);
    end
    conclude();
  end
endmodule : preset_speed_auto_sequencer_tb
`default_nettype wire
